// ===== rtl/opc_pkg.sv
// package: register map, field layout, timing constants and carrier types of the output driver control block
package opc_pkg;

  // ==========================================================
  // register map (page 1)
  localparam logic [7:0] PAGE_DRV = 8'h01;
  localparam logic [7:0] ADDR_SPK_CTRL = 8'h20;
  localparam logic [7:0] ADDR_POP_SET = 8'h21;

  // ==========================================================
  // speaker_driver_control fields
  localparam int SPK_PWR_BIT = 7;
  localparam int SPK_RSV_HI = 6;
  localparam int SPK_RSV_LO = 1;
  localparam int SPK_SHORT_BIT = 0;
  localparam logic [5:0] SPK_RSV_RESET = 6'h03;

  // headphone_pop_removal_settings fields
  localparam int POP_DAC_LATE_BIT = 7;
  localparam int POP_PON_HI = 6;
  localparam int POP_PON_LO = 3;
  localparam int POP_STEP_HI = 2;
  localparam int POP_STEP_LO = 1;
  localparam int POP_CM_BIT = 0;
  localparam logic [7:0] POP_RESET = 8'h3e;

  // ==========================================================
  // timing: nominal oscillator and wait times in nanoseconds
  localparam longint OSC_KHZ = 64'd8200;
  localparam int TICK_W = 27;
  localparam longint PON_NS [16] = '{
    64'd0, 64'd15300, 64'd153000, 64'd1530000,
    64'd15300000, 64'd76200000, 64'd153000000, 64'd304000000,
    64'd610000000, 64'd1530000000, 64'd3040000000, 64'd6100000000,
    64'd0, 64'd0, 64'd0, 64'd0};
  localparam longint STEP_NS [4] = '{64'd0, 64'd980000, 64'd1950000, 64'd3900000};
  localparam logic [3:0] RAMP_STEPS = 4'h8;

  // oscillator ticks for a time, rounded down; nonzero times give at least one tick
  function automatic logic [TICK_W-1:0] ticks_of(input longint ns, input int unsigned div);
    longint t;
    t = (ns * OSC_KHZ) / 64'd1000000 / longint'(div);
    if (ns != 0 && t == 0) begin
      t = 1;
    end
    return t[TICK_W-1:0];
  endfunction

  // ==========================================================
  // carrier types
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } opc_req_t;

  typedef enum {ST_OFF, ST_WAIT_ON, ST_RAMP, ST_ON, ST_PD} opc_state_t;

endpackage

// ===== rtl/opc_code_lut.sv
// code to oscillator-tick lookup for power-on wait and ramp step
`timescale 1ns/10ps
module opc_code_lut #(
  parameter int unsigned SIM_DIV = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // codes
  input wire logic [3:0] pon_code,
  input wire logic [1:0] step_code,
  // tick counts
  output logic [opc_pkg::TICK_W-1:0] pon_ticks,
  output logic [opc_pkg::TICK_W-1:0] step_ticks
);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pon_ticks <= '0;
    end else begin
      pon_ticks <= opc_pkg::ticks_of(opc_pkg::PON_NS[pon_code], SIM_DIV);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      step_ticks <= '0;
    end else begin
      step_ticks <= opc_pkg::ticks_of(opc_pkg::STEP_NS[step_code], SIM_DIV);
    end
  end

endmodule

// ===== rtl/opc_wait_timer.sv
// countdown of oscillator ticks with a one-cycle expiry pulse
`timescale 1ns/10ps
module opc_wait_timer (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // control
  input wire logic load,
  input wire logic [opc_pkg::TICK_W-1:0] ticks,
  input wire logic osc_tick,
  // status
  output logic expired
);

  logic [opc_pkg::TICK_W-1:0] remain;
  logic busy;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      remain <= '0;
      busy <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (load) begin
        remain <= ticks;
        busy <= (ticks != '0);
        expired <= (ticks == '0);
      end else if (busy && osc_tick) begin
        // time runs only on oscillator ticks, so it scales with the real oscillator
        remain <= remain - 1'b1;
        if (remain == 1) begin
          busy <= 1'b0;
          expired <= 1'b1;
        end
      end
    end
  end

endmodule

// ===== rtl/opc_ctrl.sv
// output driver power and pop-removal control: registers and sequencer
`timescale 1ns/10ps
module opc_ctrl #(
  parameter int unsigned SIM_DIV = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input opc_pkg::opc_req_t req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // oscillator and analog status
  input wire logic osc_tick,
  input wire logic class_d_short,
  input wire logic amps_off,
  // power requests
  input wire logic power_up_req,
  input wire logic sw_power_down,
  // driver controls
  output logic class_d_amplifier_en,
  output logic cm_reserved_sel,
  output logic drv_enable,
  output logic ramp_step,
  output logic ramp_done,
  output logic dac_power_down,
  output logic short_event
);

  // ==========================================================
  // registers
  logic [5:0] spk_rsv;
  logic [7:0] pop_set;
  logic hit_spk;
  logic hit_pop;

  // the page comes with each request; there is no page register in this block
  assign hit_spk = (req.page == opc_pkg::PAGE_DRV) && (req.addr == opc_pkg::ADDR_SPK_CTRL);
  assign hit_pop = (req.page == opc_pkg::PAGE_DRV) && (req.addr == opc_pkg::ADDR_POP_SET);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      class_d_amplifier_en <= 1'b0;
    end else if (req.wr && hit_spk) begin
      class_d_amplifier_en <= req.wdata[opc_pkg::SPK_PWR_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      spk_rsv <= opc_pkg::SPK_RSV_RESET;
    end else if (req.wr && hit_spk) begin
      // reserved bits are stored as written; software keeps the pattern
      spk_rsv <= req.wdata[opc_pkg::SPK_RSV_HI:opc_pkg::SPK_RSV_LO];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pop_set <= opc_pkg::POP_RESET;
    end else if (req.wr && hit_pop) begin
      pop_set <= req.wdata;
    end
  end

  // the code lookup is registered, so it lags a write to the pop settings by one edge;
  // a power-up must not start on the stale wait time in that edge
  logic pop_fresh;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pop_fresh <= 1'b0;
    end else begin
      pop_fresh <= req.wr && hit_pop;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cm_reserved_sel <= 1'b0;
    end else begin
      cm_reserved_sel <= pop_set[opc_pkg::POP_CM_BIT];
    end
  end

  // ==========================================================
  // read path
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= req.rd;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= 8'h00;
    end else if (!req.rd) begin
      rd_data <= 8'h00;
    end else if (hit_spk) begin
      rd_data <= {class_d_amplifier_en, spk_rsv, class_d_short};
    end else if (hit_pop) begin
      rd_data <= pop_set;
    end else begin
      rd_data <= 8'h00;
    end
  end

  // ==========================================================
  // short detection event for the sticky flag
  logic short_prev;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      short_prev <= 1'b0;
      short_event <= 1'b0;
    end else begin
      short_prev <= class_d_short;
      // only meaningful while the driver is up, so ignore it otherwise
      short_event <= class_d_short && !short_prev && class_d_amplifier_en;
    end
  end

  // ==========================================================
  // timing
  logic [opc_pkg::TICK_W-1:0] pon_ticks;
  logic [opc_pkg::TICK_W-1:0] step_ticks;
  logic tmr_load;
  logic [opc_pkg::TICK_W-1:0] tmr_ticks;
  logic tmr_expired;

  opc_code_lut #(
    .SIM_DIV(SIM_DIV)
  ) u_lut (
    .core_clk(core_clk),
    .nrst(nrst),
    .pon_code(pop_set[opc_pkg::POP_PON_HI:opc_pkg::POP_PON_LO]),
    .step_code(pop_set[opc_pkg::POP_STEP_HI:opc_pkg::POP_STEP_LO]),
    .pon_ticks(pon_ticks),
    .step_ticks(step_ticks)
  );

  opc_wait_timer u_tmr (
    .core_clk(core_clk),
    .nrst(nrst),
    .load(tmr_load),
    .ticks(tmr_ticks),
    .osc_tick(osc_tick),
    .expired(tmr_expired)
  );

  // ==========================================================
  // power sequencer
  opc_pkg::opc_state_t state;
  opc_pkg::opc_state_t next_state;
  // the step count is fixed; the coded step time alone sets how long the ramp takes
  logic [3:0] steps_left;

  always_comb begin
    next_state = state;
    tmr_load = 1'b0;
    tmr_ticks = pon_ticks;
    case (state)
      opc_pkg::ST_OFF: begin
        if (sw_power_down) begin
          next_state = opc_pkg::ST_PD;
        end else if (power_up_req && !pop_fresh) begin
          tmr_load = 1'b1;
          next_state = opc_pkg::ST_WAIT_ON;
        end
      end
      opc_pkg::ST_WAIT_ON, opc_pkg::ST_RAMP: begin
        if (sw_power_down) begin
          next_state = opc_pkg::ST_PD;
        end else if (!power_up_req) begin
          next_state = opc_pkg::ST_OFF;
        end else if (tmr_expired) begin
          if (state == opc_pkg::ST_RAMP && steps_left == 4'h1) begin
            next_state = opc_pkg::ST_ON;
          end else begin
            tmr_load = 1'b1;
            tmr_ticks = step_ticks;
            next_state = opc_pkg::ST_RAMP;
          end
        end
      end
      opc_pkg::ST_ON: begin
        if (sw_power_down) begin
          next_state = opc_pkg::ST_PD;
        end else if (!power_up_req) begin
          next_state = opc_pkg::ST_OFF;
        end
      end
      opc_pkg::ST_PD: begin
        if (!sw_power_down) begin
          next_state = opc_pkg::ST_OFF;
        end
      end
      default: begin
        next_state = opc_pkg::ST_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= opc_pkg::ST_OFF;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      steps_left <= 4'h0;
    end else if (state == opc_pkg::ST_WAIT_ON) begin
      steps_left <= opc_pkg::RAMP_STEPS;
    end else if (state == opc_pkg::ST_RAMP && tmr_expired) begin
      steps_left <= steps_left - 4'h1;
    end
  end

  // ==========================================================
  // driver outputs, decoded from the state being entered so they change with it
  logic next_drv_enable;
  logic next_ramp_step;
  logic next_ramp_done;

  always_comb begin
    next_drv_enable = 1'b0;
    next_ramp_step = 1'b0;
    next_ramp_done = 1'b0;
    case (next_state)
      opc_pkg::ST_WAIT_ON: begin
        next_drv_enable = 1'b1;
      end
      opc_pkg::ST_RAMP: begin
        next_drv_enable = 1'b1;
        next_ramp_step = tmr_load;
      end
      opc_pkg::ST_ON: begin
        next_drv_enable = 1'b1;
        next_ramp_done = 1'b1;
      end
      default: begin
        next_drv_enable = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      drv_enable <= 1'b0;
    end else begin
      drv_enable <= next_drv_enable;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ramp_step <= 1'b0;
    end else begin
      ramp_step <= next_ramp_step;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ramp_done <= 1'b0;
    end else begin
      ramp_done <= next_ramp_done;
    end
  end

  // ==========================================================
  // DAC power-down order
  // late mode holds the DAC up until the amplifiers report off, to keep pop low
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dac_power_down <= 1'b0;
    end else if (next_state != opc_pkg::ST_PD) begin
      dac_power_down <= 1'b0;
    end else if (!pop_set[opc_pkg::POP_DAC_LATE_BIT]) begin
      dac_power_down <= 1'b1;
    end else begin
      dac_power_down <= amps_off;
    end
  end

endmodule

// ===== testbench/opc_ctrl_properties.sv
// checker: port-level properties of the output driver control block
`timescale 1ns/10ps
module opc_ctrl_properties (
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input opc_pkg::opc_req_t req,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  // status and controls
  input wire logic class_d_short,
  input wire logic sw_power_down,
  input wire logic class_d_amplifier_en,
  input wire logic cm_reserved_sel,
  input wire logic drv_enable,
  input wire logic ramp_step,
  input wire logic ramp_done,
  input wire logic short_event
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // decode of accesses to the two registers
  logic wr20;
  logic wr21;
  logic rd20;
  assign wr20 = req.wr && req.page == 8'h01 && req.addr == 8'h20;
  assign wr21 = req.wr && req.page == 8'h01 && req.addr == 8'h21;
  assign rd20 = req.rd && req.page == 8'h01 && req.addr == 8'h20;
  // ==========================================================
  // properties
  property p_en;
    wr20 |=> class_d_amplifier_en == $past(req.wdata[7]);
  endproperty
  a_en: assert property (p_en) else $error("power bit not taken from write");
  property p_rd20;
    rd20 |=> rd_valid && rd_data[0] == $past(class_d_short);
  endproperty
  a_rd20: assert property (p_rd20) else $error("short status bit wrong on read");
  property p_sev;
    $rose(class_d_short) && class_d_amplifier_en |=> short_event;
  endproperty
  a_sev: assert property (p_sev) else $error("short event missing");
  property p_sev1;
    short_event |=> !short_event;
  endproperty
  a_sev1: assert property (p_sev1) else $error("short event longer than a cycle");
  property p_ev0;
    !class_d_amplifier_en |=> !short_event;
  endproperty
  a_ev0: assert property (p_ev0) else $error("short event while driver off");
  property p_pd;
    sw_power_down |=> !drv_enable && !ramp_done;
  endproperty
  a_pd: assert property (p_pd) else $error("driver still on in power-down");
  property p_rdone;
    ramp_done |-> drv_enable;
  endproperty
  a_rdone: assert property (p_rdone) else $error("ramp done without driver enable");
  property p_cm;
    wr21 |=> ##1 cm_reserved_sel == $past(req.wdata[0], 2);
  endproperty
  a_cm: assert property (p_cm) else $error("common-mode select not taken");
  c_step: cover property (ramp_step);
  c_sev: cover property (short_event);
  c_rd20: cover property (rd20);
endmodule
bind opc_ctrl opc_ctrl_properties u_props (.core_clk, .nrst, .req, .rd_data, .rd_valid, .class_d_short,
  .sw_power_down, .class_d_amplifier_en, .cm_reserved_sel, .drv_enable, .ramp_step, .ramp_done, .short_event);

// ===== testbench/opc_ctrl_tb.sv
// testbench: register access and power sequencing of the output driver control block
`timescale 1ns/10ps
module opc_ctrl_tb;
  logic core_clk = 0;
  logic nrst = 0;
  logic osc_tick = 0;
  logic class_d_short = 0;
  logic amps_off = 0;
  logic power_up_req = 0;
  logic sw_power_down = 0;
  opc_pkg::opc_req_t req = '0;
  logic [7:0] rd_data;
  logic rd_valid, class_d_amplifier_en, cm_reserved_sel, drv_enable;
  logic ramp_step, ramp_done, dac_power_down, short_event;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;

  opc_ctrl #(.SIM_DIV(1)) u_dut (.core_clk, .nrst, .req, .rd_data, .rd_valid, .osc_tick, .class_d_short,
    .amps_off, .power_up_req, .sw_power_down, .class_d_amplifier_en, .cm_reserved_sel, .drv_enable,
    .ramp_step, .ramp_done, .dac_power_down, .short_event);

  // ==========================================================
  // clock, oscillator pulses every other cycle, hang guard
  always #50 core_clk = ~core_clk;
  always @(negedge core_clk) osc_tick <= ~osc_tick;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // tasks
  task chk(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk) req <= '{1'b1, 1'b0, 8'h01, a, d};
    @(negedge core_clk) req <= '0;
  endtask
  // read is answered on the same edge that takes it, and checked at the falling edge after it
  task rdc(input logic [7:0] p, input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk) req <= '{1'b0, 1'b1, p, a, 8'h00};
    @(negedge core_clk) req <= '0;
    chk(rd_valid, 8'h01);
    chk(rd_data, e);
  endtask
  task waitn(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  task tally_and_finish;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    waitn(4);
    nrst <= 1;
    rdc(8'h01, 8'h20, 8'h06);
    rdc(8'h01, 8'h21, 8'h3e);
    rdc(8'h00, 8'h20, 8'h00);
    rdc(8'h01, 8'h22, 8'h00);
    wr(8'h20, 8'h86);
    chk(class_d_amplifier_en, 8'h01);
    class_d_short <= 1;
    n = 0;
    repeat (3) begin
      @(negedge core_clk);
      n += short_event;
    end
    chk(n[7:0], 8'h01);
    rdc(8'h01, 8'h20, 8'h87);
    class_d_short <= 0;
    wr(8'h20, 8'h06);
    chk(class_d_amplifier_en, 8'h00);
    rdc(8'h01, 8'h20, 8'h06);
    // the select output is a registered copy of the stored bit, one edge later
    wr(8'h21, 8'h01);
    waitn(1);
    chk(cm_reserved_sel, 8'h01);
    wr(8'h21, 8'h00);
    waitn(1);
    chk(cm_reserved_sel, 8'h00);
    rdc(8'h01, 8'h21, 8'h00);
    // zero wait and zero step: eight quick ramp steps
    power_up_req <= 1;
    n = 0;
    repeat (40) begin
      @(negedge core_clk);
      n += ramp_step;
    end
    chk(n[7:0], 8'h08);
    chk(ramp_done, 8'h01);
    sw_power_down <= 1;
    waitn(3);
    chk(drv_enable, 8'h00);
    chk(dac_power_down, 8'h01);
    sw_power_down <= 0;
    power_up_req <= 0;
    waitn(3);
    // 15.3 us is 125 oscillator ticks, two core cycles each here
    wr(8'h21, 8'h88);
    power_up_req <= 1;
    n = 0;
    while (ramp_step !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    chk(n >= 248 && n <= 256, 8'h01);
    waitn(40);
    chk(ramp_done, 8'h01);
    // late DAC power-down waits for the amplifiers
    sw_power_down <= 1;
    waitn(3);
    chk(dac_power_down, 8'h00);
    amps_off <= 1;
    waitn(3);
    chk(dac_power_down, 8'h01);
    sw_power_down <= 0;
    power_up_req <= 0;
    amps_off <= 0;
    waitn(3);
    tally_and_finish();
  end
endmodule
